// ==== hw/psw_pkg.sv ====
package psw_pkg;
   // Register byte offsets on the host register port.
   localparam logic [7:0]  PSW_ADDR_WFCTRL   = 8'h2a;
   localparam logic [7:0]  PSW_ADDR_WF_FIRST = 8'h30;
   localparam logic [7:0]  PSW_ADDR_WF_LAST  = 8'h6b;
   localparam logic [7:0]  PSW_ADDR_WAKETIME = 8'h7e;
   localparam logic [7:0]  PSW_ADDR_IRQ_EN   = 8'h90;
   localparam logic [7:0]  PSW_ADDR_IRQ_STAT = 8'h92;
   localparam logic [7:0]  PSW_ADDR_PMGMT    = 8'hd4;
   localparam logic [7:0]  PSW_ADDR_LINKDIAG = 8'hf6;
   // Reset values of the writable registers.
   localparam logic [15:0] PSW_RST_REG       = 16'h0000;
   localparam logic [15:0] PSW_RST_WAKETIME  = 16'h0100;
   // Power mode field, bits 1:0 of the power management register.
   localparam logic [1:0]  PSW_MODE_NORMAL   = 2'b00;
   localparam logic [1:0]  PSW_MODE_ENERGY   = 2'b01;
   localparam logic [1:0]  PSW_MODE_SOFTDOWN = 2'b10;
   localparam logic [1:0]  PSW_MODE_SAVING   = 2'b11;
   // Field positions.
   localparam int          PSW_PM_EVT_EN_BIT = 8;
   localparam int          PSW_LD_SAVE_BIT   = 10;
   localparam int          PSW_WFC_MAGIC_BIT = 7;
   localparam int          PSW_IRQ_ENERGY    = 2;
   localparam int          PSW_IRQ_LINKUP    = 3;
   localparam int          PSW_IRQ_MAGIC     = 4;
   localparam int          PSW_IRQ_WFRAME    = 5;
   localparam logic [15:0] PSW_IRQ_WAKE_MASK = 16'h003c;
   // Remote wake pattern shape.
   localparam logic [7:0]  PSW_SYNC_BYTE     = 8'hff;
   localparam logic [2:0]  PSW_SYNC_COUNT    = 3'h6;
   localparam logic [2:0]  PSW_ADDR_BYTES    = 3'h6;
   localparam logic [4:0]  PSW_ADDR_COPIES   = 5'h10;
   // Wake frame definitions: four of six 16-bit words each.
   localparam int          PSW_WF_DEFS       = 4;
   localparam int          PSW_WF_WORDS      = 6;
   localparam logic [6:0]  PSW_WF_SPAN       = 7'h40;
   // Reflected CRC-32 constants.
   localparam logic [31:0] PSW_CRC_INIT      = 32'hffffffff;
   localparam logic [31:0] PSW_CRC_POLY      = 32'hedb88320;
   localparam logic [31:0] PSW_CRC_RESIDUE   = 32'hdebb20e3;
   // Energy wake-up time unit and its cycle count at 100 MHz.
   localparam int          PSW_CLK_NS        = 10;
   localparam int          PSW_WAKE_UNIT_NS  = 1000;
   localparam int          PSW_WAKE_UNIT_CYC = (PSW_WAKE_UNIT_NS + PSW_CLK_NS - 1) / PSW_CLK_NS;
   // Remote wake scanner states.
   typedef enum logic [2:0] {
      PSW_SC_SYNC  = 3'b001,
      PSW_SC_ADDR  = 3'b010,
      PSW_SC_FOUND = 3'b100
   } psw_scan_e;
endpackage

// ==== hw/psw_crc32_byte.sv ====
`timescale 1ns/1ns
// Byte-serial reflected CRC-32 accumulator with a registered result.
module psw_crc32_byte (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_init,
   input  wire logic        i_en,
   input  wire logic [7:0]  i_data,
   output logic      [31:0] o_crc
);
   import psw_pkg::*;

   logic [31:0] crc_base;   // Fresh seed on a frame's first byte, else the running value.
   logic [31:0] next_crc;   // Value after folding in the current byte.

   // Fold one byte, least significant bit first.
   always_comb begin
      crc_base = i_init ? PSW_CRC_INIT : o_crc;
      next_crc = crc_base;
      for (int b = 0; b < 8; b++) begin
         if (next_crc[0] ^ i_data[b]) begin
            next_crc = (next_crc >> 1) ^ PSW_CRC_POLY;
         end else begin
            next_crc = next_crc >> 1;
         end
      end
   end

   // A start marker reseeds, folding in its own byte when one comes with it, so that no
   // frame inherits the remainder of the frame before it.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_crc <= PSW_CRC_INIT;
      end else if (i_en) begin
         o_crc <= next_crc;
      end else if (i_init) begin
         o_crc <= PSW_CRC_INIT;
      end
   end
endmodule

// ==== hw/psw_power_wake.sv ====
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////////////////
module psw_power_wake #(
   parameter int WAKE_UNIT_CYC = psw_pkg::PSW_WAKE_UNIT_CYC   // Cycles per wake-up time unit.
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_chip_powerdown_pin,   // Low powers the chip down.
   input  wire logic        i_reg_wr,               // Register write strobe.
   input  wire logic        i_reg_rd,               // Register read strobe.
   input  wire logic [7:0]  i_reg_addr,             // Byte offset, even.
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   input  wire logic        i_auto_neg_en,          // Auto-negotiation enabled.
   input  wire logic        i_cable_energy,         // Energy present on the cable.
   input  wire logic        i_link_up,              // Link state.
   input  wire logic [47:0] i_station_addr,         // First sent byte in bits 47:40.
   input  wire logic        i_rx_sof,               // First byte of a frame.
   input  wire logic        i_rx_valid,             // Byte valid.
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_rx_eof,               // With the last byte of a frame.
   input  wire logic        i_rx_addr_match,        // Frame addressed to this node.
   output logic             o_power_saving,
   output logic             o_phy_tx_on,
   output logic             o_phy_rx_on,
   output logic             o_chip_powered_down,
   output logic             o_host_irq_n,
   output logic             o_power_mgmt_event_out
);
   import psw_pkg::*;

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Register storage and decode.

   logic [15:0] power_mgmt_event_ctrl;                   // Mode and event output enable.
   logic [15:0] port_link_diag_ctrl;                     // Port power-save bit.
   logic [15:0] wake_frame_ctrl;                         // Definition enables and scan enable.
   logic [15:0] irq_enable_mask;                         // Interrupt mask.
   logic [15:0] irq_status;                              // Sticky wake events.
   logic [15:0] wake_time;                               // Energy wake-up time, high byte.
   logic [15:0] wf_word [PSW_WF_DEFS][PSW_WF_WORDS];     // Masks and CRCs of the definitions.

   wire         clr_all   = ~i_chip_powerdown_pin;       // Held clear while powered down.
   wire         in_wf     = (i_reg_addr >= PSW_ADDR_WF_FIRST) && (i_reg_addr <= PSW_ADDR_WF_LAST);
   wire  [1:0]  wf_def    = 2'(i_reg_addr[7:4] - 4'h3);
   wire  [2:0]  wf_wrd    = i_reg_addr[3:1];
   wire         wf_hit    = in_wf && (wf_wrd < 3'(PSW_WF_WORDS));
   wire         wr_pm     = i_reg_wr && (i_reg_addr == PSW_ADDR_PMGMT);
   wire         wr_ld     = i_reg_wr && (i_reg_addr == PSW_ADDR_LINKDIAG);
   wire         wr_wfc    = i_reg_wr && (i_reg_addr == PSW_ADDR_WFCTRL);
   wire         wr_ier    = i_reg_wr && (i_reg_addr == PSW_ADDR_IRQ_EN);
   wire         wr_isr    = i_reg_wr && (i_reg_addr == PSW_ADDR_IRQ_STAT);
   wire         wr_wt     = i_reg_wr && (i_reg_addr == PSW_ADDR_WAKETIME);
   logic [15:0] rd_mux;                                  // Selected read value.
   logic [15:0] evt_set;                                 // Events of this cycle.

   // Plain control registers; the power-down pin clears them like a chip reset.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         power_mgmt_event_ctrl <= PSW_RST_REG;
         port_link_diag_ctrl   <= PSW_RST_REG;
         wake_frame_ctrl       <= PSW_RST_REG;
         irq_enable_mask       <= PSW_RST_REG;
         wake_time             <= PSW_RST_WAKETIME;
      end else if (clr_all) begin
         power_mgmt_event_ctrl <= PSW_RST_REG;
         port_link_diag_ctrl   <= PSW_RST_REG;
         wake_frame_ctrl       <= PSW_RST_REG;
         irq_enable_mask       <= PSW_RST_REG;
         wake_time             <= PSW_RST_WAKETIME;
      end else begin
         // Writes are taken in every mode, power saving included.
         if (wr_pm)  power_mgmt_event_ctrl <= i_reg_wdata;
         if (wr_ld)  port_link_diag_ctrl   <= i_reg_wdata;
         if (wr_wfc) wake_frame_ctrl       <= i_reg_wdata;
         if (wr_ier) irq_enable_mask       <= i_reg_wdata;
         if (wr_wt)  wake_time             <= i_reg_wdata;
      end
   end

   // Definition words, one writer per definition and word.
   for (genvar d = 0; d < PSW_WF_DEFS; d++) begin : g_wf_regs
      for (genvar w = 0; w < PSW_WF_WORDS; w++) begin : g_word
         wire hit = i_reg_wr && wf_hit && (wf_def == 2'(d)) && (wf_wrd == 3'(w));
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               wf_word[d][w] <= PSW_RST_REG;
            end else if (clr_all) begin
               wf_word[d][w] <= PSW_RST_REG;
            end else if (hit) begin
               wf_word[d][w] <= i_reg_wdata;
            end
         end
      end
   end

   // Status is write-one-to-clear; a new event in the same cycle wins over the clear.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_status <= PSW_RST_REG;
      end else if (clr_all) begin
         irq_status <= PSW_RST_REG;
      end else begin
         irq_status <= ((wr_isr ? (irq_status & ~i_reg_wdata) : irq_status) | evt_set) & PSW_IRQ_WAKE_MASK;
      end
   end

   // Read selection; unmapped offsets read as zero.
   always_comb begin
      rd_mux = 16'h0000;
      if (wf_hit) begin
         rd_mux = wf_word[wf_def][wf_wrd];
      end else begin
         case (i_reg_addr)
            PSW_ADDR_PMGMT:    rd_mux = power_mgmt_event_ctrl;
            PSW_ADDR_LINKDIAG: rd_mux = port_link_diag_ctrl;
            PSW_ADDR_WFCTRL:   rd_mux = wake_frame_ctrl;
            PSW_ADDR_IRQ_EN:   rd_mux = irq_enable_mask;
            PSW_ADDR_IRQ_STAT: rd_mux = irq_status;
            PSW_ADDR_WAKETIME: rd_mux = wake_time;
            default:           rd_mux = 16'h0000;
         endcase
      end
   end

   // Read data is held until the next read strobe; power-down clears it to zero.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= 16'h0000;
      end else if (clr_all) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rd_mux;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Power modes.

   wire [1:0] pm_mode   = power_mgmt_event_ctrl[1:0];
   wire       save_cond = i_auto_neg_en && !i_cable_energy && (pm_mode == PSW_MODE_SAVING)
                          && port_link_diag_ctrl[PSW_LD_SAVE_BIT];

   // Saving mode is left as soon as the host changes the mode or clears bit 10.
   // Receiver comes back by itself once cable energy returns.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_power_saving      <= 1'b0;
         o_phy_rx_on         <= 1'b0;
         o_phy_tx_on         <= 1'b0;
         o_chip_powered_down <= 1'b1;
      end else begin
         o_chip_powered_down <= clr_all;
         o_power_saving      <= !clr_all && save_cond;
         o_phy_tx_on         <= !clr_all;
         o_phy_rx_on         <= !clr_all && !save_cond;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Energy and link events.

   logic [15:0] unit_cnt;      // Cycles within one wake-up time unit.
   logic [7:0]  energy_units;  // Whole units of continuous energy.
   logic        energy_done;   // Event already raised for this energy run.
   logic        link_q;        // Link state one cycle ago.
   wire         unit_tick  = (unit_cnt == 16'(WAKE_UNIT_CYC - 1));
   wire         energy_evt = i_cable_energy && !energy_done && unit_tick && (energy_units >= wake_time[15:8]);

   // Energy must stay present without a gap; any drop restarts the measurement.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         unit_cnt     <= 16'h0000;
         energy_units <= 8'h00;
         energy_done  <= 1'b0;
         link_q       <= 1'b0;
      end else if (clr_all || !i_cable_energy) begin
         unit_cnt     <= 16'h0000;
         energy_units <= 8'h00;
         energy_done  <= 1'b0;
         link_q       <= clr_all ? 1'b0 : i_link_up;
      end else begin
         link_q   <= i_link_up;
         unit_cnt <= unit_tick ? 16'h0000 : unit_cnt + 16'h0001;
         if (unit_tick && energy_units != 8'hff) energy_units <= energy_units + 8'h01;
         if (energy_evt) energy_done <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Frame checks: full frame CRC and one masked CRC per wake definition.

   wire         rx_byte = i_rx_valid;
   logic [6:0]  byte_idx;             // Byte position, saturates at the definition span.
   logic [31:0] fcs_crc;              // Whole-frame CRC including FCS.
   logic [3:0]  wf_match;             // Per-definition CRC match at frame end.
   wire  [6:0]  cur_idx = i_rx_sof ? 7'h00 : byte_idx;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         byte_idx <= 7'h00;
      end else if (rx_byte) begin
         byte_idx <= (cur_idx == PSW_WF_SPAN) ? cur_idx : cur_idx + 7'h01;
      end
   end

   psw_crc32_byte u_fcs (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_init    (i_rx_sof),
      .i_en      (rx_byte),
      .i_data    (i_rx_data),
      .o_crc     (fcs_crc)
   );

   wire fcs_ok_now = (fcs_crc == PSW_CRC_RESIDUE);   // Sampled one cycle after the last byte.

   for (genvar d = 0; d < PSW_WF_DEFS; d++) begin : g_wf_crc
      wire [63:0]  msk  = {wf_word[d][3], wf_word[d][2], wf_word[d][1], wf_word[d][0]};
      wire [31:0]  want = {wf_word[d][5], wf_word[d][4]};
      wire         take = rx_byte && (cur_idx < PSW_WF_SPAN) && msk[cur_idx[5:0]];
      logic [31:0] crc;
      // Only bytes selected by the mask enter the definition's CRC.
      psw_crc32_byte u_crc (
         .i_sys_clk (i_sys_clk),
         .i_rstn    (i_rstn),
         .i_init    (i_rx_sof),
         .i_en      (take),
         .i_data    (i_rx_data),
         .o_crc     (crc)
      );
      assign wf_match[d] = wake_frame_ctrl[d] && (~crc == want);
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Remote wake pattern scanner.

   psw_scan_e   scan_st;           // Scanner state.
   logic [2:0]  sync_cnt;          // FF bytes seen in a row.
   logic [2:0]  addr_pos;          // Byte within one address copy.
   logic [4:0]  copy_cnt;          // Completed address copies.
   logic        frame_end_q;       // Frame ended last cycle; CRC results now valid.
   logic        frame_addr_q;      // Address match of that frame.
   wire  [7:0]  want_byte = i_station_addr[8'(47 - 8 * addr_pos) -: 8];
   wire         is_sync   = (i_rx_data == PSW_SYNC_BYTE);
   wire         scan_on   = wake_frame_ctrl[PSW_WFC_MAGIC_BIT];

   // A broken sequence restarts the hunt, reusing the breaking byte if it is FF.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scan_st  <= PSW_SC_SYNC;
         sync_cnt <= 3'h0;
         addr_pos <= 3'h0;
         copy_cnt <= 5'h00;
      end else if (i_rx_sof && !rx_byte) begin
         scan_st  <= PSW_SC_SYNC;
         sync_cnt <= 3'h0;
      end else if (rx_byte) begin
         case ((i_rx_sof && scan_st != PSW_SC_SYNC) ? PSW_SC_SYNC : scan_st)
            PSW_SC_SYNC: begin
               addr_pos <= 3'h0;
               copy_cnt <= 5'h00;
               if (!is_sync) begin
                  sync_cnt <= 3'h0;
                  scan_st  <= PSW_SC_SYNC;
               end else if ((i_rx_sof ? 3'h0 : sync_cnt) == PSW_SYNC_COUNT - 3'h1) begin
                  sync_cnt <= PSW_SYNC_COUNT;
                  scan_st  <= PSW_SC_ADDR;
               end else begin
                  sync_cnt <= (i_rx_sof ? 3'h0 : sync_cnt) + 3'h1;
                  scan_st  <= PSW_SC_SYNC;
               end
            end
            PSW_SC_ADDR: begin
               if (i_rx_data == want_byte) begin
                  addr_pos <= (addr_pos == PSW_ADDR_BYTES - 3'h1) ? 3'h0 : addr_pos + 3'h1;
                  if (addr_pos == PSW_ADDR_BYTES - 3'h1) begin
                     copy_cnt <= copy_cnt + 5'h01;
                     if (copy_cnt == PSW_ADDR_COPIES - 5'h01) scan_st <= PSW_SC_FOUND;
                  end
               end else if (is_sync && addr_pos == 3'h0 && copy_cnt == 5'h00) begin
                  scan_st <= PSW_SC_ADDR;                                 // Extra FF keeps sync.
               end else begin
                  scan_st  <= PSW_SC_SYNC;
                  sync_cnt <= is_sync ? 3'h1 : 3'h0;
                  addr_pos <= 3'h0;
                  copy_cnt <= 5'h00;
               end
            end
            PSW_SC_FOUND: scan_st <= PSW_SC_FOUND;                        // Pattern anywhere counts.
            default:      scan_st <= PSW_SC_SYNC;
         endcase
      end
   end

   // Frame end is acted on one cycle late so the registered CRCs include the last byte.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         frame_end_q  <= 1'b0;
         frame_addr_q <= 1'b0;
      end else begin
         frame_end_q  <= rx_byte && i_rx_eof && !clr_all;
         frame_addr_q <= i_rx_addr_match;
      end
   end

   // Frames without the pattern, with a bad CRC, or not for this node raise no magic event; a wake frame match needs only a good CRC.
   wire magic_evt  = frame_end_q && scan_on && frame_addr_q && fcs_ok_now
                     && (scan_st == PSW_SC_FOUND);
   wire wframe_evt = frame_end_q && fcs_ok_now && (|wf_match);

   always_comb begin
      evt_set                  = 16'h0000;
      evt_set[PSW_IRQ_ENERGY]  = energy_evt;
      evt_set[PSW_IRQ_LINKUP]  = i_link_up && !link_q;
      evt_set[PSW_IRQ_MAGIC]   = magic_evt;
      evt_set[PSW_IRQ_WFRAME]  = wframe_evt;
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // Host signalling from the sticky status.

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_host_irq_n           <= 1'b1;
         o_power_mgmt_event_out <= 1'b0;
      end else begin
         o_host_irq_n           <= clr_all || ~|(irq_status & irq_enable_mask);
         o_power_mgmt_event_out <= !clr_all && power_mgmt_event_ctrl[PSW_PM_EVT_EN_BIT]
                                   && |(irq_status & PSW_IRQ_WAKE_MASK);
      end
   end
endmodule

// ==== verif/psw_power_wake_monitor.sv ====
`timescale 1ns/1ns
// Port-level checks on power saving, power-down and wake signalling.
module psw_power_wake_monitor (
   input wire logic        i_sys_clk,
   input wire logic        i_rstn,
   input wire logic        i_chip_powerdown_pin,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic        i_auto_neg_en,
   input wire logic        i_cable_energy,
   input wire logic        i_link_up,
   input wire logic        i_rx_eof,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        o_power_saving,
   input wire logic        o_phy_tx_on,
   input wire logic        o_phy_rx_on,
   input wire logic        o_chip_powered_down,
   input wire logic        o_host_irq_n,
   input wire logic        o_power_mgmt_event_out
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // Any cause that may legally move the wake outputs.
   wire ev = i_reg_wr | i_rx_eof | i_link_up | i_cable_energy;
   chk_save_needs_cond: assert property (o_power_saving |-> $past(i_auto_neg_en) && !$past(i_cable_energy))
      else $error("saving without its conditions");
   chk_rx_off_save: assert property (!o_chip_powered_down |-> o_phy_rx_on == !o_power_saving)
      else $error("receiver state disagrees with saving");
   chk_tx_stays_on: assert property (!o_chip_powered_down |-> o_phy_tx_on)
      else $error("transmitter off while powered");
   chk_save_exit_energy: assert property (o_power_saving && i_cable_energy |=> !o_power_saving)
      else $error("saving kept despite line activity");
   chk_pd_clears_all: assert property (!i_chip_powerdown_pin |=> o_chip_powered_down && o_host_irq_n
      && !o_power_mgmt_event_out && !o_power_saving)
      else $error("power-down left outputs active");
   chk_rdata_holds: assert property (!i_reg_rd && i_chip_powerdown_pin ##1 i_chip_powerdown_pin
      |-> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   chk_event_has_cause: assert property ($rose(o_power_mgmt_event_out) |-> $past(ev) || $past(ev, 2)
      || $past(ev, 3))
      else $error("event output rose without a cause");
   chk_irq_has_cause: assert property ($fell(o_host_irq_n) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
      else $error("interrupt fell without a cause");
   cover property ($rose(o_power_saving));
   cover property ($fell(o_host_irq_n));
   cover property ($rose(o_power_mgmt_event_out));
endmodule
bind psw_power_wake psw_power_wake_monitor u_mon (.i_sys_clk, .i_rstn, .i_chip_powerdown_pin, .i_reg_wr,
   .i_reg_rd, .i_auto_neg_en, .i_cable_energy, .i_link_up, .i_rx_eof, .o_reg_rdata, .o_power_saving,
   .o_phy_tx_on, .o_phy_rx_on, .o_chip_powered_down, .o_host_irq_n, .o_power_mgmt_event_out);

// ==== verif/psw_link_partner.sv ====
`timescale 1ns/1ns
// Far-side partner: plays one frame from its buffer with the FCS appended.
module psw_link_partner (
   input  wire logic       i_sys_clk,
   output logic            o_sof,
   output logic            o_valid,
   output logic      [7:0] o_data,
   output logic            o_eof
);
   logic [7:0] mem [0:127];   // Frame body, loaded by the bench.
   initial begin
      {o_sof, o_valid, o_eof} = 3'h0;
      o_data = 8'h00;
   end
   // A corrupted FCS is the only wrong thing this partner ever sends.
   task automatic send(input int n, input bit bad);
      logic [31:0] crc;
      logic [7:0]  b;
      crc = psw_pkg::PSW_CRC_INIT;
      for (int i = 0; i < n + 4; i++) begin
         b = (i < n) ? mem[i] : ~crc[8*(i-n) +: 8];   // Valid frame, FCS low byte first.
         if (i == n + 3 && bad) b = ~b;
         @(posedge i_sys_clk); #1;
         o_sof = (i == 0); o_valid = 1'b1; o_data = b; o_eof = (i == n + 3);
         if (i < n) for (int k = 0; k < 8; k++) crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? psw_pkg::PSW_CRC_POLY : 0);
      end
      @(posedge i_sys_clk); #1;
      {o_sof, o_valid, o_eof} = 3'h0;
      o_data = ~o_data;   // Released lines must not look like data.
   endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   import psw_pkg::*;
   logic        clk, rstn, pin, wr, rd, an, en, lk, am, sof, vld, eof, sav, txo, rxo, pdn, irqn, power_mgmt_event_out;
   logic [7:0]  addr, dat;
   logic [15:0] wd, rdata;
   logic [47:0] sta = 48'h112233445566;
   int          miscompares = 0, samples_checked = 0;
   logic [31:0] wcrc;   // Reference check value of wake definition 0.
   psw_power_wake #(.WAKE_UNIT_CYC(2)) dut (.i_sys_clk(clk), .i_rstn(rstn), .i_chip_powerdown_pin(pin),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
      .i_auto_neg_en(an), .i_cable_energy(en), .i_link_up(lk), .i_station_addr(sta), .i_rx_sof(sof),
      .i_rx_valid(vld), .i_rx_data(dat), .i_rx_eof(eof), .i_rx_addr_match(am), .o_power_saving(sav),
      .o_phy_tx_on(txo), .o_phy_rx_on(rxo), .o_chip_powered_down(pdn), .o_host_irq_n(irqn),
      .o_power_mgmt_event_out(power_mgmt_event_out));
   psw_link_partner lp (.i_sys_clk(clk), .o_sof(sof), .o_valid(vld), .o_data(dat), .o_eof(eof));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Standard CRC-32 over the first n frame bytes, inverted, as a wake definition holds it.
   function automatic logic [31:0] ref_crc(input int n);
      logic [31:0] c;
      c = PSW_CRC_INIT;
      for (int i = 0; i < n; i++)
         for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ lp.mem[i][k]) ? PSW_CRC_POLY : 32'h0);
      return ~c;
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk); #1; wr = 1; addr = a; wd = d;
      @(posedge clk); #1; wr = 0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk); #1; rd = 1; addr = a;
      @(posedge clk); #1; rd = 0;
      `CHK(rdata, e)
   endtask
   task automatic complete_run;
      $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // The whole run needs well under 20 us; this cuts a hang short.
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
   initial begin
      {rstn, wr, rd, an, en, lk} = 6'h0; {pin, am} = 2'b11; addr = 8'h00; wd = 16'h0000;
      repeat (16) @(posedge clk);
      #1 rstn = 1;
      rd_chk(PSW_ADDR_WFCTRL, PSW_RST_REG);
      rd_chk(PSW_ADDR_WAKETIME, PSW_RST_WAKETIME);
      rd_chk(8'h04, 16'h0000);
      $display("test defaults done");
      an = 1; wr_reg(PSW_ADDR_PMGMT, 16'h0003); wr_reg(PSW_ADDR_LINKDIAG, 16'h0400); wait_n(3);
      `CHK({sav, txo, rxo}, 3'b110)
      rd_chk(PSW_ADDR_PMGMT, 16'h0003);
      en = 1; wait_n(20);
      `CHK({sav, rxo}, 2'b01)
      rd_chk(PSW_ADDR_IRQ_STAT, 16'h0004);
      en = 0; wr_reg(PSW_ADDR_IRQ_STAT, 16'h0004);
      wr_reg(PSW_ADDR_LINKDIAG, 16'h0000); wr_reg(PSW_ADDR_PMGMT, {14'h0, PSW_MODE_NORMAL}); wait_n(3);
      `CHK(sav, 1'b0)
      $display("test power saving done");
      wr_reg(PSW_ADDR_IRQ_EN, PSW_IRQ_WAKE_MASK); wr_reg(PSW_ADDR_PMGMT, 16'h0100); lk = 1; wait_n(3);
      `CHK({irqn, power_mgmt_event_out}, 2'b01)
      rd_chk(PSW_ADDR_IRQ_STAT, 16'h0008);
      wr_reg(PSW_ADDR_IRQ_STAT, 16'h0008); wait_n(3);
      `CHK({irqn, power_mgmt_event_out}, 2'b10)
      $display("test link up done");
      for (int i = 0; i < 114; i++)
         lp.mem[i] = (i < 12) ? 8'(i + 1) : (i < 18) ? PSW_SYNC_BYTE : sta[47 - 8 * ((i - 18) % 6) -: 8];
      // Scan off, bad FCS, not for this node, then a good frame: only the last one wakes.
      for (int k = 0; k < 4; k++) begin
         wr_reg(PSW_ADDR_WFCTRL, (k > 0) ? 16'h0080 : 16'h0000);
         am = (k != 2);
         lp.send(114, k == 1); wait_n(4);
         rd_chk(PSW_ADDR_IRQ_STAT, (k == 3) ? 16'h0010 : 16'h0000);
         `CHK(power_mgmt_event_out, k == 3)
      end
      $display("test remote wake done");
      wcrc = ref_crc(4);
      wr_reg(PSW_ADDR_WF_FIRST, 16'h000f);
      wr_reg(PSW_ADDR_WF_FIRST + 8'h0a, wcrc[31:16]);
      wr_reg(PSW_ADDR_WFCTRL, 16'h0001);
      // Right check value first, then one with a flipped bit that must not wake.
      for (int j = 0; j < 2; j++) begin
         wr_reg(PSW_ADDR_IRQ_STAT, PSW_IRQ_WAKE_MASK);
         wr_reg(PSW_ADDR_WF_FIRST + 8'h08, wcrc[15:0] ^ 16'(j));
         lp.send(114, 1'b0); wait_n(4);
         rd_chk(PSW_ADDR_IRQ_STAT, (j == 0) ? 16'h0020 : 16'h0000);
      end
      $display("test wake frame done");
      pin = 0; wait_n(5);
      `CHK({pdn, power_mgmt_event_out}, 2'b10)
      pin = 1; wait_n(2);
      rd_chk(PSW_ADDR_PMGMT, PSW_RST_REG);
      rd_chk(PSW_ADDR_WFCTRL, PSW_RST_REG);
      wr_reg(PSW_ADDR_IRQ_EN, PSW_IRQ_WAKE_MASK);
      rd_chk(PSW_ADDR_IRQ_EN, PSW_IRQ_WAKE_MASK);
      $display("test power down done");
      complete_run();
   end
endmodule
